// File: fasl_pkg.sv
package fasl_pkg;
  // register map, one byte each on the serial bus command space
  localparam logic [7:0] REG_LOAD_VOLTAGE_TRIM = 8'h19;
  localparam logic [7:0] REG_ALERT_SELECT_FIRST = 8'h1a;
  localparam logic [7:0] REG_ALERT_SELECT_SECOND = 8'h1b;
  localparam logic [7:0] REG_MAKER_IDENTITY = 8'h1c;
  localparam logic [7:0] REG_SILICON_REVISION = 8'h1d;
  localparam logic [7:0] REG_LATCHED_FAULT_STATUS_ONE = 8'h2a;

  // nonvolatile copy locations, used by the loader outside this block
  localparam logic [15:0] NVM_LOAD_VOLTAGE_TRIM = 16'h8119;
  localparam logic [15:0] NVM_ALERT_SELECT_FIRST = 16'h811a;
  localparam logic [15:0] NVM_ALERT_SELECT_SECOND = 16'h811b;

  // reset values until the nonvolatile load arrives
  localparam logic [7:0] RST_LATCHED_STATUS = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [7:0] RST_SELECT = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // second select register field positions
  localparam int SEL_B_FORCE_BIT = 2;
  localparam int SEL_B_UNUSED_BIT = 0;

  // revision field layout
  localparam int REV_MAJOR_LSB = 4;
  localparam int REV_MINOR_LSB = 0;

  // internal fault and monitor flags, active high meaning fault present
  typedef struct packed {
    logic ov_fault;
    logic uv_fault;
    logic ocp_timeout;
    logic mains_sense_bad;
    logic ocp_flag;
    logic over_temp;
    logic output_switch_bad;
    logic load_share_bad;
    logic supply_bad;
    logic monitor_input_one_flag;
    logic monitor_input_two_flag;
    logic monitor_input_three_flag;
    logic monitor_input_four_flag;
    logic monitor_input_five_flag;
  } fasl_flags_t;

  // serial bus pins as seen from inside (data line is open drain)
  typedef struct packed {
    logic scl;
    logic sda;
  } fasl_smb_in_t;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_WR, S_RD, S_ACK, S_RACK} fasl_state_t;
endpackage

// File: fasl_top.sv
`timescale 1ns/1ns
// Summary of operation
// - alert is OR of all enabled flags
// - first select bits map eight fault flags
// - second select: supply, monitors, host force bit
// - select registers load from nonvolatile copy
// - read/write trim register loads from nonvolatile copy
// - read-only fixed maker identity register
// - revision: major high nibble, minor low nibble
// - latched status resets to zero, eight sources
// - latched bits set on rising edge only
// - status read clears bits unless fault persists
module fasl_top
  import fasl_pkg::*;
#(
  parameter logic [6:0] SMB_ADDR = 7'h50,
  parameter logic [7:0] MAKER_ID_CODE = 8'h5a, // arbitrary value
  parameter logic [3:0] REV_MAJOR = 4'h3, // arbitrary value
  parameter logic [3:0] REV_MINOR = 4'h0 // arbitrary value, the revision index
) (
  input wire logic core_clk, // device clock, 50 MHz
  input wire logic srst, // synchronous reset, active high
  input wire fasl_flags_t flags, // internal fault and monitor flags
  input wire logic nvm_load, // one-cycle pulse, nonvolatile copies valid
  input wire logic [7:0] nvm_trim, // nonvolatile trim copy
  input wire logic [7:0] nvm_sel_a, // nonvolatile first select copy
  input wire logic [7:0] nvm_sel_b, // nonvolatile second select copy
  input wire fasl_smb_in_t smb_in, // bus clock and data line level
  output logic smb_sda_out, // data line drive value, always low
  output logic smb_sda_oe, // high while pulling data line low
  output logic shared_alert_pin, // alert, active high
  output logic [7:0] load_voltage_trim // trim to the voltage loop
);
  fasl_smb_in_t sync1;
  fasl_smb_in_t sync2;
  fasl_smb_in_t sync3;
  logic [7:0] alert_enable_group_a;
  logic [7:0] alert_enable_group_b;
  logic [7:0] latched_fault_status_one;
  logic [7:0] prev_src;
  fasl_state_t state;
  fasl_state_t after_ack;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [7:0] cmd;
  logic [3:0] bitcnt;
  logic byte_rdy;

  // pins pass three flops; only sync2 and sync3 are looked at
  always_ff @(posedge core_clk) begin
    sync1 <= smb_in;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  wire scl_rise = sync2.scl & ~sync3.scl;
  wire scl_fall = ~sync2.scl & sync3.scl;
  wire bus_start = sync2.scl & sync3.scl & ~sync2.sda & sync3.sda;
  wire bus_stop = sync2.scl & sync3.scl & sync2.sda & ~sync3.sda;

  // select vectors in register bit order
  wire [7:0] group_a_src = {flags.ov_fault, flags.uv_fault, flags.ocp_timeout, flags.mains_sense_bad,
                            flags.ocp_flag, flags.over_temp, flags.output_switch_bad,
                            flags.load_share_bad};
  wire [7:0] group_b_src = {flags.supply_bad, flags.monitor_input_one_flag, flags.monitor_input_two_flag,
                            flags.monitor_input_three_flag, flags.monitor_input_four_flag, 1'b1,
                            flags.monitor_input_five_flag, 1'b0};
  wire host_alert_force = alert_enable_group_b[SEL_B_FORCE_BIT];
  wire any_alert = |(alert_enable_group_a & group_a_src) | |(alert_enable_group_b & group_b_src);

  // latch sources: three fault flags and the five monitor flags, a subset of the alert path
  wire [7:0] latch_src = {flags.ov_fault, flags.uv_fault, flags.ocp_timeout, flags.monitor_input_one_flag,
                          flags.monitor_input_two_flag, flags.monitor_input_three_flag,
                          flags.monitor_input_four_flag, flags.monitor_input_five_flag};
  wire [7:0] src_rise = latch_src & ~prev_src;

  // read data mux; identity and revision are fixed
  wire [7:0] revision_word = {REV_MAJOR, REV_MINOR};
  wire [7:0] rd_data = (cmd == REG_LOAD_VOLTAGE_TRIM) ? load_voltage_trim :
                       (cmd == REG_ALERT_SELECT_FIRST) ? alert_enable_group_a :
                       (cmd == REG_ALERT_SELECT_SECOND) ? alert_enable_group_b :
                       (cmd == REG_MAKER_IDENTITY) ? MAKER_ID_CODE :
                       (cmd == REG_SILICON_REVISION) ? revision_word :
                       (cmd == REG_LATCHED_FAULT_STATUS_ONE) ? latched_fault_status_one : UNMAPPED_READ;

  // byte load happens on the falling edge that ends an ack slot
  wire tx_load = scl_fall & ~byte_rdy & (state == S_ACK) & (after_ack == S_RD);
  wire rd_clr = tx_load & (cmd == REG_LATCHED_FAULT_STATUS_ONE);
  wire wr_en = scl_fall & byte_rdy & (state == S_WR);
  wire addr_hit = (shift[7:1] == SMB_ADDR);

  // a fresh edge beats the read clear; a persisting fault keeps its bit
  wire [7:0] clr_mask = rd_clr ? ~latch_src : 8'h00;
  wire [7:0] next_status = (latched_fault_status_one & ~clr_mask) | src_rise;

  // alert recomputed every cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shared_alert_pin <= 1'b0;
    end else begin
      shared_alert_pin <= any_alert;
    end
  end

  // latched status with edge memory
  always_ff @(posedge core_clk) begin
    if (srst) begin
      latched_fault_status_one <= RST_LATCHED_STATUS;
      prev_src <= 8'h00;
    end else begin
      latched_fault_status_one <= next_status;
      prev_src <= latch_src;
    end
  end

  // writable registers; nonvolatile load wins over a bus write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      load_voltage_trim <= RST_TRIM;
      alert_enable_group_a <= RST_SELECT;
      alert_enable_group_b <= RST_SELECT;
    end else if (nvm_load) begin
      load_voltage_trim <= nvm_trim;
      alert_enable_group_a <= nvm_sel_a;
      alert_enable_group_b <= nvm_sel_b;
    end else if (wr_en) begin
      if (cmd == REG_LOAD_VOLTAGE_TRIM) begin
        load_voltage_trim <= shift;
      end
      if (cmd == REG_ALERT_SELECT_FIRST) begin
        alert_enable_group_a <= shift;
      end
      if (cmd == REG_ALERT_SELECT_SECOND) begin
        alert_enable_group_b <= shift;
      end
    end
  end

  // serial slave: bits sampled on clock rise, data line changed on fall
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= S_IDLE;
      after_ack <= S_IDLE;
      shift <= 8'h00;
      tx <= 8'h00;
      cmd <= 8'h00;
      bitcnt <= 4'h0;
      byte_rdy <= 1'b0;
      smb_sda_out <= 1'b0;
      smb_sda_oe <= 1'b0;
    end else if (bus_start) begin
      state <= S_ADDR; // repeated start keeps the command byte
      bitcnt <= 4'h0;
      byte_rdy <= 1'b0;
      smb_sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state <= S_IDLE;
      byte_rdy <= 1'b0;
      smb_sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        S_ADDR, S_CMD, S_WR: begin
          shift <= {shift[6:0], sync2.sda};
          bitcnt <= bitcnt + 4'h1;
          byte_rdy <= (bitcnt == 4'h7);
        end
        S_RD: begin
          bitcnt <= bitcnt + 4'h1;
          if (bitcnt == 4'h7) begin
            state <= S_RACK;
          end
        end
        S_RACK: begin
          // master nack ends the read; ack fetches the same register again
          state <= sync2.sda ? S_IDLE : S_ACK;
          after_ack <= S_RD;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      if (byte_rdy) begin
        byte_rdy <= 1'b0;
        case (state)
          S_ADDR: begin
            state <= addr_hit ? S_ACK : S_IDLE;
            smb_sda_oe <= addr_hit;
            after_ack <= shift[0] ? S_RD : S_CMD;
          end
          S_CMD: begin
            cmd <= shift;
            state <= S_ACK;
            smb_sda_oe <= 1'b1;
            after_ack <= S_WR;
          end
          default: begin
            state <= S_ACK;
            smb_sda_oe <= 1'b1;
            after_ack <= S_WR;
          end
        endcase
      end else begin
        case (state)
          S_ACK: begin
            state <= after_ack;
            bitcnt <= 4'h0;
            if (after_ack == S_RD) begin
              tx <= {rd_data[6:0], 1'b0};
              smb_sda_oe <= ~rd_data[7];
            end else begin
              smb_sda_oe <= 1'b0;
            end
          end
          S_RD: begin
            tx <= {tx[6:0], 1'b0};
            smb_sda_oe <= ~tx[7];
          end
          default: begin
            smb_sda_oe <= 1'b0; // release for the master ack slot
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_read_clear;
    rd_clr;
  endsequence
  sequence s_ov_rises;
    flags.ov_fault && !prev_src[7];
  endsequence
  property p_alert_or;
    any_alert |=> shared_alert_pin;
  endproperty
  a_alert_or: assert property (p_alert_or) else $error("enabled flag did not raise alert");

  property p_alert_quiet;
    !any_alert |=> !shared_alert_pin;
  endproperty
  a_alert_quiet: assert property (p_alert_quiet) else $error("alert without enabled flag");

  property p_ov_select;
    (flags.ov_fault && alert_enable_group_a[7]) |=> shared_alert_pin;
  endproperty
  a_ov_select: assert property (p_ov_select) else $error("overvoltage select ignored");

  property p_force;
    host_alert_force |=> shared_alert_pin;
  endproperty
  a_force: assert property (p_force) else $error("host force did not raise alert");

  property p_nvm_load;
    nvm_load |=> (alert_enable_group_a == $past(nvm_sel_a)) && (alert_enable_group_b == $past(nvm_sel_b));
  endproperty
  a_nvm_load: assert property (p_nvm_load) else $error("select not loaded from nvm");

  property p_trim_load;
    nvm_load |=> load_voltage_trim == $past(nvm_trim);
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim not loaded from nvm");

  // checked where the byte enters the shifter, so the mux and the load path are both covered
  property p_fixed_id;
    (tx_load && cmd == REG_MAKER_IDENTITY) |=> {!smb_sda_oe, tx[7:1]} == MAKER_ID_CODE;
  endproperty
  a_fixed_id: assert property (p_fixed_id) else $error("identity read wrong");

  property p_revision;
    (tx_load && cmd == REG_SILICON_REVISION) |=> {!smb_sda_oe, tx[7:1]} == {REV_MAJOR, REV_MINOR};
  endproperty
  a_revision: assert property (p_revision) else $error("revision read wrong");

  property p_status_reset;
    $past(srst) |-> latched_fault_status_one == RST_LATCHED_STATUS;
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status not zero after reset");

  property p_edge_sets;
    s_ov_rises |=> latched_fault_status_one[7];
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("rising edge not latched");

  property p_no_level_set;
    $rose(latched_fault_status_one[7]) |-> $past(src_rise[7]);
  endproperty
  a_no_level_set: assert property (p_no_level_set) else $error("status set without edge");

  property p_read_clears;
    s_read_clear |=> ((latched_fault_status_one & ~$past(latch_src) & ~$past(src_rise)) == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear idle bits");

  property p_persist;
    s_read_clear ##0 (flags.ov_fault && latched_fault_status_one[7]) |=> latched_fault_status_one[7];
  endproperty
  a_persist: assert property (p_persist) else $error("persisting fault cleared");
endmodule

// File: fasl_host_model.sv
`timescale 1ns/1ns
// bus master in the host's place; bus clock stands high between frames
module fasl_host_model (
  input wire logic core_clk, // device clock, paces the bus
  input wire logic sda_oe, // device pulls data line low
  output logic scl, // bus clock, 160 ns period in frames
  output logic sda // data line level after pull-up
);
  logic host_low;
  // open drain: released line floats up through the pull-up
  assign sda = ~(host_low | sda_oe);
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask
  // data moves one clock after the fall so the device never sees it beside the edge
  task automatic bit_io(input logic b, output logic r);
    @(negedge core_clk);
    host_low = ~b;
    repeat (3) @(negedge core_clk);
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  // ninth bit always released: ack from device, or no-ack closing a read
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, ack);
  endtask
  // serves as repeated start as well
  task automatic start();
    @(negedge core_clk);
    host_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    host_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    @(negedge core_clk);
    host_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    host_low = 1'b0;
    half();
  endtask
  task automatic wr(input logic [6:0] adr, input logic [7:0] cmd, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer({adr, 1'b0}, rx, a0);
    xfer(cmd, rx, a1);
    xfer(d, rx, a2);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask
  task automatic rd(input logic [6:0] adr, input logic [7:0] cmd, output logic [7:0] q, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start();
    xfer({adr, 1'b0}, rx, a0);
    xfer(cmd, rx, a1);
    start();
    xfer({adr, 1'b1}, rx, a2);
    xfer(8'hff, q, a3);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ns
module testbench;
  import fasl_pkg::*;
  localparam logic [6:0] DEV = 7'h50;
  localparam logic [7:0] ID_CODE = 8'h5a; // arbitrary value
  localparam logic [3:0] REV_MAJ = 4'h3; // arbitrary value
  localparam logic [3:0] REV_MIN = 4'h1; // arbitrary value
  localparam logic [7:0] ST = REG_LATCHED_FAULT_STATUS_ONE;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  fasl_flags_t flags = '0;
  logic nvm_load = 1'b0;
  logic [7:0] nvm_trim = 8'h00;
  logic [7:0] nvm_sel_a = 8'h00;
  logic [7:0] nvm_sel_b = 8'h00;
  logic scl, sda, sda_oe, alert;
  logic sda_out;
  logic [7:0] trim;
  int n_fail = 0;
  int tests_run = 0;
  always #10 core_clk = ~core_clk;
  fasl_top #(.SMB_ADDR(DEV), .MAKER_ID_CODE(ID_CODE), .REV_MAJOR(REV_MAJ), .REV_MINOR(REV_MIN)) fasl_top_inst (
    .core_clk(core_clk), .srst(srst), .flags(flags), .nvm_load(nvm_load), .nvm_trim(nvm_trim),
    .nvm_sel_a(nvm_sel_a), .nvm_sel_b(nvm_sel_b), .smb_in({scl, sda}), .smb_sda_out(sda_out),
    .smb_sda_oe(sda_oe), .shared_alert_pin(alert), .load_voltage_trim(trim));
  // open drain: the line goes low only when enabled and the drive value is low
  fasl_host_model fasl_host_model_inst (.core_clk(core_clk), .sda_oe(sda_oe & ~sda_out), .scl(scl), .sda(sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] cmd, input logic [7:0] d);
    logic ok;
    fasl_host_model_inst.wr(DEV, cmd, d, ok);
    chk({7'h00, ok}, 8'h01, "write acked");
  endtask
  task automatic rchk(input logic [7:0] cmd, input logic [7:0] exp, input string what);
    logic ok;
    logic [7:0] q;
    fasl_host_model_inst.rd(DEV, cmd, q, ok);
    chk({7'h00, ok}, 8'h01, "read acked");
    chk(q, exp, what);
  endtask
  task automatic t_reset();
    chk(trim, RST_TRIM, "trim after reset");
    chk({7'h00, alert}, 8'h00, "alert after reset");
    rchk(ST, 8'h00, "status after reset");
    $display("test reset done");
  endtask
  // nonvolatile copies land in one pulse; second select keeps the force bit clear
  task automatic t_nvm();
    nvm_trim = 8'ha5;
    nvm_sel_a = 8'h3c;
    nvm_sel_b = 8'hfa;
    nvm_load = 1'b1;
    @(negedge core_clk);
    nvm_load = 1'b0;
    @(negedge core_clk);
    chk(trim, 8'ha5, "trim port from copy");
    rchk(REG_LOAD_VOLTAGE_TRIM, 8'ha5, "trim from copy");
    rchk(REG_ALERT_SELECT_FIRST, 8'h3c, "first select from copy");
    rchk(REG_ALERT_SELECT_SECOND, 8'hfa, "second select from copy");
    $display("test nvm done");
  endtask
  task automatic t_regs();
    logic ok;
    logic [7:0] q;
    wreg(REG_LOAD_VOLTAGE_TRIM, 8'h3e);
    chk(trim, 8'h3e, "trim port after write");
    rchk(REG_LOAD_VOLTAGE_TRIM, 8'h3e, "trim readback");
    // test-only access; normal host traffic leaves these two alone
    wreg(REG_MAKER_IDENTITY, 8'hff);
    wreg(REG_SILICON_REVISION, 8'hff);
    rchk(REG_MAKER_IDENTITY, ID_CODE, "identity fixed");
    rchk(REG_SILICON_REVISION, {REV_MAJ, REV_MIN}, "revision fields");
    rchk(8'h20, UNMAPPED_READ, "unmapped read");
    fasl_host_model_inst.rd(7'h51, REG_LOAD_VOLTAGE_TRIM, q, ok);
    chk({7'h00, ok}, 8'h00, "foreign address refused");
    chk(q, 8'hff, "foreign address leaves line released");
    $display("test regs done");
  endtask
  // one select bit at a time against its own flag, then against all the others
  task automatic t_alert();
    for (int i = 0; i < 14; i++) begin
      wreg(REG_ALERT_SELECT_FIRST, (i >= 6) ? 8'h01 << (i - 6) : 8'h00);
      wreg(REG_ALERT_SELECT_SECOND, (i >= 6) ? 8'h00 : 8'h01 << ((i == 0) ? 1 : i + 2));
      flags = 14'h0001 << i;
      @(negedge core_clk);
      chk({7'h00, alert}, 8'h01, "selected flag raises alert");
      flags = ~(14'h0001 << i);
      @(negedge core_clk);
      chk({7'h00, alert}, 8'h00, "other flags stay quiet");
      flags = '0;
    end
    wreg(REG_ALERT_SELECT_FIRST, 8'h00);
    wreg(REG_ALERT_SELECT_SECOND, 8'h01);
    flags = '1;
    repeat (2) @(negedge core_clk);
    chk({7'h00, alert}, 8'h00, "unused select bit");
    flags = '0;
    wreg(REG_ALERT_SELECT_SECOND, 8'h04);
    chk({7'h00, alert}, 8'h01, "host force");
    wreg(REG_ALERT_SELECT_SECOND, 8'h00);
    chk({7'h00, alert}, 8'h00, "force removed");
    $display("test alert done");
  endtask
  task automatic t_latch();
    rchk(ST, 8'hff, "every source latched");
    flags = 14'h07e0;
    repeat (2) @(negedge core_clk);
    flags = '0;
    rchk(ST, 8'h00, "read cleared, unlatched sources ignored");
    for (int k = 0; k < 8; k++) begin
      flags = 14'h0001 << ((k >= 5) ? k + 6 : k);
      repeat (2) @(negedge core_clk);
      flags = '0;
      rchk(ST, 8'h01 << k, "single source position");
    end
    flags.ov_fault = 1'b1;
    repeat (2) @(negedge core_clk);
    rchk(ST, 8'h80, "fault latched");
    rchk(ST, 8'h80, "persisting fault stays");
    flags.ov_fault = 1'b0;
    repeat (2) @(negedge core_clk);
    rchk(ST, 8'h80, "kept until next read");
    rchk(ST, 8'h00, "reread after fault gone");
    $display("test latch done");
  endtask
  // reset in mid-run with a latched bit, a forced alert and a written trim all pending
  task automatic t_midreset();
    wreg(REG_ALERT_SELECT_SECOND, 8'h04);
    flags.ov_fault = 1'b1;
    repeat (2) @(negedge core_clk);
    flags.ov_fault = 1'b0;
    srst = 1'b1;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    chk(trim, RST_TRIM, "trim after second reset");
    chk({7'h00, alert}, 8'h00, "alert after second reset");
    rchk(ST, RST_LATCHED_STATUS, "status after second reset");
    rchk(REG_ALERT_SELECT_SECOND, RST_SELECT, "select after second reset");
    $display("test midreset done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    t_reset();
    t_nvm();
    t_regs();
    t_alert();
    t_latch();
    t_midreset();
    finish_test();
  end
  // run needs about 17000 clocks
  initial begin
    repeat (60000) @(negedge core_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
